// ==== hdl/mem_routing_cfg.svh ====
`ifndef MEM_ROUTING_CFG_SVH
`define MEM_ROUTING_CFG_SVH

// register offsets within the 256-location control block
`define OFS_PORT_A_PIN_INPUT     8'h00
`define OFS_PORT_B_PIN_INPUT     8'h01
`define OFS_PORT_A_PIN_FUNCTION  8'h02
`define OFS_PORT_B_PIN_FUNCTION  8'h03
`define OFS_PORT_A_PIN_OUTPUT    8'h04
`define OFS_PORT_B_PIN_OUTPUT    8'h05
`define OFS_PORT_A_PIN_DIR       8'h06
`define OFS_PORT_B_PIN_DIR       8'h07
`define OFS_PORT_C_PIN_INPUT     8'h10
`define OFS_PORT_D_PIN_INPUT     8'h11
`define OFS_PORT_C_PIN_OUTPUT    8'h12
`define OFS_PORT_D_PIN_OUTPUT    8'h13
`define OFS_PORT_C_PIN_DIR       8'h14
`define OFS_PORT_D_PIN_DIR       8'h15
`define OFS_MEMORY_SPACE_MAP     8'hE2

// memory_space_map field positions
`define MSM_PERIPHERAL_IO_ENABLE_BIT           7
`define MSM_MAIN_DATA_BIT        4
`define MSM_SEC_DATA_BIT         3
`define MSM_MAIN_PROG_BIT        2
`define MSM_SEC_PROG_BIT         1
`define MSM_ROUTING_MASK         8'h1E

// reset values of the port registers
`define PORT_REG_RESET           8'h00

`endif

// ==== hdl/mem_routing_pkg.sv ====
package mem_routing_pkg;

    // kind of bus cycle seen this clock
    typedef enum logic [1:0] {
        CYC_IDLE,
        CYC_DATA_READ,
        CYC_DATA_WRITE,
        CYC_FETCH
    } cycle_kind_type;

    // data width driven for the cycle
    typedef enum logic {
        WIDTH_8,
        WIDTH_16
    } bus_width_type;

endpackage : mem_routing_pkg

// ==== hdl/pin_sync.sv ====
// two-stage synchroniser for a group of pin levels
module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk_in,
    input  wire logic             rstn_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : pin_sync

// ==== hdl/port_pin_ctl.sv ====
// per-pin output driver control for one port
module port_pin_ctl #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk_in,
    input  wire logic             rstn_in,
    input  wire logic [WIDTH-1:0] level_in,
    input  wire logic [WIDTH-1:0] dir_in,
    input  wire logic [WIDTH-1:0] addr_sel_in,
    input  wire logic [WIDTH-1:0] addr_bits_in,
    input  wire logic [WIDTH-1:0] cell_sel_in,
    input  wire logic [WIDTH-1:0] cell_val_in,
    output logic      [WIDTH-1:0] pin_out,
    output logic      [WIDTH-1:0] pin_oe_n_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_pin
            // macrocell output wins over the data-out register
            always_ff @(posedge core_clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    pin_out[i]      <= 1'b0;
                    pin_oe_n_out[i] <= 1'b1;
                end else if (cell_sel_in[i]) begin
                    pin_out[i]      <= cell_val_in[i]; // [R17]
                    pin_oe_n_out[i] <= 1'b0;
                end else if (addr_sel_in[i]) begin
                    pin_out[i]      <= addr_bits_in[i]; // [R16]
                    pin_oe_n_out[i] <= 1'b0;
                end else begin
                    pin_out[i]      <= level_in[i];
                    pin_oe_n_out[i] <= ~dir_in[i]; // [R18]
                end
            end
        end
    endgenerate
endmodule : port_pin_ctl

// ==== hdl/memory_space_routing_regs.sv ====
// Operation
// [R1] map bit 4 set lets data reads and writes reach main flash.
// [R2] map bit 3 set lets data reads and writes reach secondary flash.
// [R3] map bit 2 set lets program fetches reach main flash.
// [R4] map bit 1 set lets program fetches reach secondary flash.
// [R5] map bit 7 enables port A peripheral mode, resets to zero.
// [R6] routing bits reload from the nonvolatile default on every reset.
// [R7] processor writes replace routing until the next reset.
// [R8] sram and control registers decode in data space only.
// [R9] program fetch cycles drive a 16-bit word, others are 8-bit.
// [R10] flash in both spaces: 16-bit on fetch, 8-bit on data cycles.
// [R11] flash command writes and status reads use 8-bit width.
// [R12] sram, registers and external selects are always 8-bit.
// [R13] registers decode at a movable base plus fixed offset in 256.
// [R14] software must not write unused block locations; they read zero.
// [R15] pin input registers return live pin levels, writes ignored.
// [R16] port A/B function bits pick processor I/O or address output.
// [R17] data-out sets pin levels, readable, overridden by macrocell pins.
// [R18] direction bit 1 makes a pin output, 0 input; readable.
// [R19] map bits 0, 5 and 6 read zero and ignore writes.
`include "mem_routing_cfg.svh"

module memory_space_routing_regs
    import mem_routing_pkg::*;
#(
    parameter logic [7:0] NV_MAP_DEFAULT = 8'h0C,
    parameter int         PORT_WIDTH     = 8
) (
    input  wire logic                  core_clk_in,
    input  wire logic                  rstn_in,
    // processor bus, already in this clock domain
    input  wire logic [15:0]           addr_in,
    input  wire logic [7:0]            wdata_in,
    input  wire logic                  rd_n_in,
    input  wire logic                  wr_n_in,
    input  wire logic                  fetch_n_in,
    input  wire logic                  flash_prog_in,
    input  wire logic [7:0]            reg_base_in,
    input  wire logic                  main_hit_in,
    input  wire logic                  sec_hit_in,
    input  wire logic                  sram_hit_in,
    input  wire logic                  ext_hit_in,
    input  wire logic [15:0]           main_rdata_in,
    input  wire logic [15:0]           sec_rdata_in,
    input  wire logic [7:0]            sram_rdata_in,
    input  wire logic [7:0]            ext_rdata_in,
    // port pins and macrocell overrides
    input  wire logic [PORT_WIDTH-1:0] port_a_pin_in,
    input  wire logic [PORT_WIDTH-1:0] port_b_pin_in,
    input  wire logic [PORT_WIDTH-1:0] port_c_pin_in,
    input  wire logic [PORT_WIDTH-1:0] port_d_pin_in,
    input  wire logic [PORT_WIDTH-1:0] cell_sel_a_in,
    input  wire logic [PORT_WIDTH-1:0] cell_sel_b_in,
    input  wire logic [PORT_WIDTH-1:0] cell_sel_c_in,
    input  wire logic [PORT_WIDTH-1:0] cell_sel_d_in,
    input  wire logic [PORT_WIDTH-1:0] cell_val_a_in,
    input  wire logic [PORT_WIDTH-1:0] cell_val_b_in,
    input  wire logic [PORT_WIDTH-1:0] cell_val_c_in,
    input  wire logic [PORT_WIDTH-1:0] cell_val_d_in,
    // outputs
    output logic                       main_sel_out,
    output logic                       sec_sel_out,
    output logic                       sram_sel_out,
    output logic                       ext_sel_out,
    output logic [15:0]                rdata_out,
    output logic                       rdata_wide_out,
    output logic                       rdata_oe_n_out,
    output logic                       peripheral_io_enable_out,
    output logic [7:0]                 memory_space_map_out,
    output logic [PORT_WIDTH-1:0]      port_a_pin_out,
    output logic [PORT_WIDTH-1:0]      port_b_pin_out,
    output logic [PORT_WIDTH-1:0]      port_c_pin_out,
    output logic [PORT_WIDTH-1:0]      port_d_pin_out,
    output logic [PORT_WIDTH-1:0]      port_a_pin_oe_n_out,
    output logic [PORT_WIDTH-1:0]      port_b_pin_oe_n_out,
    output logic [PORT_WIDTH-1:0]      port_c_pin_oe_n_out,
    output logic [PORT_WIDTH-1:0]      port_d_pin_oe_n_out
);
    localparam logic [7:0] ROUTE_MASK = `MSM_ROUTING_MASK;

    logic [7:0]            map_q;
    logic [PORT_WIDTH-1:0] a_func_q, b_func_q;
    logic [PORT_WIDTH-1:0] a_out_q, b_out_q, c_out_q, d_out_q;
    logic [PORT_WIDTH-1:0] a_dir_q, b_dir_q, c_dir_q, d_dir_q;
    logic [PORT_WIDTH-1:0] a_sync, b_sync, c_sync, d_sync;
    logic                  wr_n_q;
    cycle_kind_type        kind;
    bus_width_type         width_d;
    logic                  reg_hit;
    logic [7:0]            reg_ofs;
    logic                  reg_wr;
    logic                  main_sel_d, sec_sel_d, sram_sel_d, ext_sel_d;
    logic [7:0]            reg_rdata;
    logic [15:0]           rdata_d;

    // pin levels come from outside; two flops before any decode reads them
    pin_sync #(.WIDTH(PORT_WIDTH)) u_sync_a (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .async_in(port_a_pin_in), .sync_out(a_sync));
    pin_sync #(.WIDTH(PORT_WIDTH)) u_sync_b (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .async_in(port_b_pin_in), .sync_out(b_sync));
    pin_sync #(.WIDTH(PORT_WIDTH)) u_sync_c (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .async_in(port_c_pin_in), .sync_out(c_sync));
    pin_sync #(.WIDTH(PORT_WIDTH)) u_sync_d (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .async_in(port_d_pin_in), .sync_out(d_sync));

    // classify the bus cycle; a fetch outranks data strobes
    always_comb begin
        if (!fetch_n_in) begin
            kind = CYC_FETCH;
        end else if (!wr_n_in) begin
            kind = CYC_DATA_WRITE;
        end else if (!rd_n_in) begin
            kind = CYC_DATA_READ;
        end else begin
            kind = CYC_IDLE;
        end
    end

    // register block sits at base plus offset, data space only
    assign reg_hit = (addr_in[15:8] == reg_base_in) && (kind != CYC_FETCH)
                     && (kind != CYC_IDLE); // [R13] [R8]
    assign reg_ofs = addr_in[7:0];
    // one write per strobe: act on the falling edge of wr_n
    assign reg_wr  = reg_hit && (kind == CYC_DATA_WRITE) && wr_n_q;

    // route strobes to memories per the map; registers and sram beat flash
    always_comb begin
        main_sel_d = 1'b0;
        sec_sel_d  = 1'b0;
        sram_sel_d = 1'b0;
        ext_sel_d  = 1'b0;
        case (kind)
            CYC_FETCH: begin
                // sram, registers and externals never join a fetch
                main_sel_d = main_hit_in && map_q[`MSM_MAIN_PROG_BIT] // [R3]
                             && !(sec_hit_in && map_q[`MSM_SEC_PROG_BIT]);
                sec_sel_d  = sec_hit_in && map_q[`MSM_SEC_PROG_BIT]; // [R4] [R12]
            end
            CYC_DATA_READ, CYC_DATA_WRITE: begin
                sram_sel_d = sram_hit_in && !reg_hit; // [R8]
                ext_sel_d  = ext_hit_in && !reg_hit && !sram_hit_in;
                sec_sel_d  = sec_hit_in && map_q[`MSM_SEC_DATA_BIT] // [R2]
                             && !reg_hit && !sram_hit_in && !ext_hit_in;
                main_sel_d = main_hit_in && map_q[`MSM_MAIN_DATA_BIT] // [R1]
                             && !reg_hit && !sram_hit_in && !ext_hit_in
                             && !(sec_hit_in && map_q[`MSM_SEC_DATA_BIT]);
            end
            default: ;
        endcase
    end

    // register read mux; unused locations read zero
    always_comb begin
        case (reg_ofs)
            `OFS_PORT_A_PIN_INPUT:    reg_rdata = a_sync; // [R15]
            `OFS_PORT_B_PIN_INPUT:    reg_rdata = b_sync;
            `OFS_PORT_C_PIN_INPUT:    reg_rdata = c_sync;
            `OFS_PORT_D_PIN_INPUT:    reg_rdata = d_sync;
            `OFS_PORT_A_PIN_FUNCTION: reg_rdata = a_func_q; // [R16]
            `OFS_PORT_B_PIN_FUNCTION: reg_rdata = b_func_q;
            `OFS_PORT_A_PIN_OUTPUT:   reg_rdata = a_out_q; // [R17]
            `OFS_PORT_B_PIN_OUTPUT:   reg_rdata = b_out_q;
            `OFS_PORT_C_PIN_OUTPUT:   reg_rdata = c_out_q;
            `OFS_PORT_D_PIN_OUTPUT:   reg_rdata = d_out_q;
            `OFS_PORT_A_PIN_DIR:      reg_rdata = a_dir_q; // [R18]
            `OFS_PORT_B_PIN_DIR:      reg_rdata = b_dir_q;
            `OFS_PORT_C_PIN_DIR:      reg_rdata = c_dir_q;
            `OFS_PORT_D_PIN_DIR:      reg_rdata = d_dir_q;
            `OFS_MEMORY_SPACE_MAP:    reg_rdata = map_q;
            default:                  reg_rdata = 8'h00; // [R14]
        endcase
    end

    // width: 16 bits only on a fetch; data and flash command cycles are bytes
    always_comb begin
        rdata_d = 16'h0000;
        width_d = WIDTH_8;
        if (kind == CYC_FETCH) begin
            width_d = WIDTH_16; // [R9]
            if (sec_sel_d) begin
                rdata_d = sec_rdata_in; // [R10]
            end else if (main_sel_d) begin
                rdata_d = main_rdata_in; // [R10]
            end
        end else if (kind == CYC_DATA_READ) begin
            // flash_prog_in status reads also land here as bytes
            if (reg_hit) begin
                rdata_d = {8'h00, reg_rdata}; // [R12]
            end else if (sram_sel_d) begin
                rdata_d = {8'h00, sram_rdata_in};
            end else if (ext_sel_d) begin
                rdata_d = {8'h00, ext_rdata_in};
            end else if (sec_sel_d) begin
                rdata_d = {8'h00, sec_rdata_in[7:0]};
            end else if (main_sel_d) begin
                rdata_d = {8'h00, main_rdata_in[7:0]}; // [R10] [R11]
            end
        end
    end

    // strobe edge tracking for single-shot register writes
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_n_q <= 1'b1;
        end else begin
            wr_n_q <= wr_n_in;
        end
    end

    // memory-space map: routing from nonvolatile default, port mode cleared
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            map_q <= NV_MAP_DEFAULT & ROUTE_MASK; // [R6] [R5]
        end else if (reg_wr && reg_ofs == `OFS_MEMORY_SPACE_MAP) begin
            map_q <= wdata_in & (ROUTE_MASK | 8'h80); // [R7] [R19]
        end
    end

    // port function, data-out and direction registers
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            a_func_q <= `PORT_REG_RESET;
            b_func_q <= `PORT_REG_RESET;
            a_out_q  <= `PORT_REG_RESET;
            b_out_q  <= `PORT_REG_RESET;
            c_out_q  <= `PORT_REG_RESET;
            d_out_q  <= `PORT_REG_RESET;
            a_dir_q  <= `PORT_REG_RESET;
            b_dir_q  <= `PORT_REG_RESET;
            c_dir_q  <= `PORT_REG_RESET;
            d_dir_q  <= `PORT_REG_RESET;
        end else if (reg_wr) begin
            // pin input offsets have no case item, so writes there are dropped
            case (reg_ofs)
                `OFS_PORT_A_PIN_FUNCTION: a_func_q <= wdata_in; // [R16]
                `OFS_PORT_B_PIN_FUNCTION: b_func_q <= wdata_in;
                `OFS_PORT_A_PIN_OUTPUT:   a_out_q  <= wdata_in; // [R17]
                `OFS_PORT_B_PIN_OUTPUT:   b_out_q  <= wdata_in;
                `OFS_PORT_C_PIN_OUTPUT:   c_out_q  <= wdata_in;
                `OFS_PORT_D_PIN_OUTPUT:   d_out_q  <= wdata_in;
                `OFS_PORT_A_PIN_DIR:      a_dir_q  <= wdata_in; // [R18]
                `OFS_PORT_B_PIN_DIR:      b_dir_q  <= wdata_in;
                `OFS_PORT_C_PIN_DIR:      c_dir_q  <= wdata_in;
                `OFS_PORT_D_PIN_DIR:      d_dir_q  <= wdata_in;
                default:                  ; // [R15]
            endcase
        end
    end

    // registered select and read data outputs
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            main_sel_out   <= 1'b0;
            sec_sel_out    <= 1'b0;
            sram_sel_out   <= 1'b0;
            ext_sel_out    <= 1'b0;
            rdata_out      <= 16'h0000;
            rdata_wide_out <= 1'b0;
            rdata_oe_n_out <= 1'b1;
        end else begin
            main_sel_out   <= main_sel_d;
            sec_sel_out    <= sec_sel_d;
            sram_sel_out   <= sram_sel_d;
            ext_sel_out    <= ext_sel_d;
            rdata_out      <= rdata_d;
            rdata_wide_out <= (width_d == WIDTH_16) && !flash_prog_in; // [R9] [R11]
            rdata_oe_n_out <= !((kind == CYC_FETCH && (main_sel_d || sec_sel_d))
                                || (kind == CYC_DATA_READ && (reg_hit || sram_sel_d
                                    || ext_sel_d || main_sel_d || sec_sel_d)));
        end
    end

    // map and peripheral mode status
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            memory_space_map_out     <= 8'h00;
            peripheral_io_enable_out <= 1'b0;
        end else begin
            memory_space_map_out     <= map_q;
            peripheral_io_enable_out <= map_q[`MSM_PERIPHERAL_IO_ENABLE_BIT]; // [R5]
        end
    end

    // pin drivers; only ports A and B can carry latched address bits
    port_pin_ctl #(.WIDTH(PORT_WIDTH)) u_pins_a (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .level_in(a_out_q), .dir_in(a_dir_q), .addr_sel_in(a_func_q),
        .addr_bits_in(addr_in[PORT_WIDTH-1:0]), .cell_sel_in(cell_sel_a_in),
        .cell_val_in(cell_val_a_in), .pin_out(port_a_pin_out),
        .pin_oe_n_out(port_a_pin_oe_n_out));
    port_pin_ctl #(.WIDTH(PORT_WIDTH)) u_pins_b (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .level_in(b_out_q), .dir_in(b_dir_q), .addr_sel_in(b_func_q),
        .addr_bits_in(addr_in[15:16-PORT_WIDTH]), .cell_sel_in(cell_sel_b_in),
        .cell_val_in(cell_val_b_in), .pin_out(port_b_pin_out),
        .pin_oe_n_out(port_b_pin_oe_n_out));
    port_pin_ctl #(.WIDTH(PORT_WIDTH)) u_pins_c (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .level_in(c_out_q), .dir_in(c_dir_q), .addr_sel_in('0),
        .addr_bits_in('0), .cell_sel_in(cell_sel_c_in),
        .cell_val_in(cell_val_c_in), .pin_out(port_c_pin_out),
        .pin_oe_n_out(port_c_pin_oe_n_out));
    port_pin_ctl #(.WIDTH(PORT_WIDTH)) u_pins_d (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .level_in(d_out_q), .dir_in(d_dir_q), .addr_sel_in('0),
        .addr_bits_in('0), .cell_sel_in(cell_sel_d_in),
        .cell_val_in(cell_val_d_in), .pin_out(port_d_pin_out),
        .pin_oe_n_out(port_d_pin_oe_n_out));

endmodule : memory_space_routing_regs

// ==== test/memory_space_routing_regs_assertions.sv ====
module msr_checker #(
    parameter logic [7:0] NV_MAP_DEFAULT = 8'h0C
) (
    input wire logic        core_clk_in,
    input wire logic        rstn_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0]  wdata_in,
    input wire logic        rd_n_in,
    input wire logic        wr_n_in,
    input wire logic        fetch_n_in,
    input wire logic [7:0]  reg_base_in,
    input wire logic        main_hit_in,
    input wire logic        sec_hit_in,
    input wire logic        sram_hit_in,
    input wire logic        ext_hit_in,
    input wire logic        main_sel_out,
    input wire logic        sec_sel_out,
    input wire logic        sram_sel_out,
    input wire logic [15:0] rdata_out,
    input wire logic        rdata_wide_out,
    input wire logic        peripheral_io_enable_out,
    input wire logic [7:0]  memory_space_map_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rstn_in);

    // flash-only cycles; no write in flight to move the map
    wire flash_only = wr_n_in && !sram_hit_in && !ext_hit_in && addr_in[15:8] != reg_base_in;
    wire data_rd    = !rd_n_in && fetch_n_in && flash_only;
    wire fetch      = !fetch_n_in && flash_only;

    AST_MAIN_DATA: assert property (
        data_rd && main_hit_in && !sec_hit_in && $past(wr_n_in)
        |=> main_sel_out == memory_space_map_out[4]) else $error("main data route");
    AST_SEC_DATA: assert property (
        data_rd && sec_hit_in && $past(wr_n_in)
        |=> sec_sel_out == memory_space_map_out[3]) else $error("sec data route");
    AST_MAIN_FETCH: assert property (
        fetch && main_hit_in && !sec_hit_in && $past(wr_n_in)
        |=> main_sel_out == memory_space_map_out[2]) else $error("main fetch route");
    AST_SEC_FETCH: assert property (
        fetch && sec_hit_in && $past(wr_n_in)
        |=> sec_sel_out == memory_space_map_out[1]) else $error("sec fetch route");
    AST_PIO: assert property (
        peripheral_io_enable_out == memory_space_map_out[7]) else $error("pio mismatch");
    AST_UNUSED: assert property (
        (memory_space_map_out & 8'h61) == 8'h00) else $error("unused map bits set");
    AST_RESET_LOAD: assert property (
        $rose(rstn_in) |=> memory_space_map_out == (NV_MAP_DEFAULT & 8'h1E))
        else $error("map default lost");
    AST_MAP_WRITE: assert property (
        !wr_n_in && $past(wr_n_in) && fetch_n_in && addr_in == {reg_base_in, 8'hE2}
        |=> ##1 memory_space_map_out == ($past(wdata_in, 2) & 8'h9E))
        else $error("map write lost");
    AST_FETCH_NO_SRAM: assert property (
        !fetch_n_in |=> !sram_sel_out) else $error("sram answered a fetch");
    AST_BYTE_CYCLE: assert property (
        !rd_n_in && wr_n_in && fetch_n_in |=> !rdata_wide_out && rdata_out[15:8] == 8'h00)
        else $error("data cycle wide");
endmodule : msr_checker

bind memory_space_routing_regs msr_checker #(.NV_MAP_DEFAULT(NV_MAP_DEFAULT)) chk (
    .core_clk_in, .rstn_in, .addr_in, .wdata_in, .rd_n_in, .wr_n_in, .fetch_n_in,
    .reg_base_in, .main_hit_in, .sec_hit_in, .sram_hit_in, .ext_hit_in, .main_sel_out,
    .sec_sel_out, .sram_sel_out, .rdata_out, .rdata_wide_out, .peripheral_io_enable_out,
    .memory_space_map_out
);

// ==== test/cpu_bus_model.sv ====
module cpu_bus_model (
    input  wire logic [15:0] rdata_in,
    input  wire logic        core_clk_in,
    output logic      [15:0] addr_out,
    output logic      [7:0]  wdata_out,
    output logic             rd_n_out,
    output logic             wr_n_out,
    output logic             fetch_n_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        {addr_out, wdata_out} = 24'h000000;
        {fetch_n_out, wr_n_out, rd_n_out} = 3'b111;
    end

    // kind is {fetch, write, read}; strobe held to the answer edge
    task automatic xfer(input logic [2:0] kind, input logic [15:0] a,
                        input logic [7:0] d, output logic [15:0] q);
        @(posedge core_clk_in);
        #1;
        addr_out = a;
        wdata_out = d;
        {fetch_n_out, wr_n_out, rd_n_out} = ~kind;
        @(posedge core_clk_in);
        @(posedge core_clk_in);
        #1;
        q = rdata_in;
        {fetch_n_out, wr_n_out, rd_n_out} = 3'b111;
        // released lines flip so a stale address never looks valid
        addr_out = ~addr_out;
        wdata_out = ~wdata_out;
    endtask : xfer
endmodule : cpu_bus_model

// ==== test/memory_space_routing_regs_tb_top.sv ====
module memory_space_routing_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0]  NV   = 8'hFF;
    localparam logic [15:0] MDAT = 16'h1234;
    localparam logic [15:0] SDAT = 16'h5678;
    logic        core_clk_in, rstn_in, rd_n_in, wr_n_in, fetch_n_in, flash_prog_in, exp;
    logic        main_hit_in, sec_hit_in, sram_hit_in, ext_hit_in, peripheral_io_enable_out;
    logic        main_sel_out, sec_sel_out, sram_sel_out, rdata_wide_out, oe_n;
    logic [15:0] addr_in, rdata_out, q, src;
    logic [7:0]  wdata_in, reg_base_in, memory_space_map_out, csel, cval, pc_out, pc_oe_n;
    logic [7:0]  pins    [4] = '{8'hA5, 8'h5A, 8'hC3, 8'h3C};
    logic [7:0]  pin_ofs [4] = '{8'h00, 8'h01, 8'h10, 8'h11};
    logic [7:0]  maps    [6] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h00, 8'h1E};
    logic [7:0]  ofs     [10] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                                  8'h12, 8'h13, 8'h14, 8'h15};
    int          fails = 0;
    int          checks_done = 0;

    memory_space_routing_regs #(.NV_MAP_DEFAULT(NV)) dut (
        .core_clk_in, .rstn_in, .addr_in, .wdata_in, .rd_n_in, .wr_n_in, .fetch_n_in,
        .flash_prog_in, .reg_base_in, .main_hit_in, .sec_hit_in, .sram_hit_in, .ext_hit_in,
        .main_rdata_in(MDAT), .sec_rdata_in(SDAT), .sram_rdata_in(8'h9A), .ext_rdata_in(8'hBC),
        .port_a_pin_in(pins[0]), .port_b_pin_in(pins[1]), .port_c_pin_in(pins[2]),
        .port_d_pin_in(pins[3]), .cell_sel_a_in(csel), .cell_sel_b_in(csel),
        .cell_sel_c_in(csel), .cell_sel_d_in(csel), .cell_val_a_in(cval),
        .cell_val_b_in(cval), .cell_val_c_in(cval), .cell_val_d_in(cval),
        .main_sel_out, .sec_sel_out, .sram_sel_out, .ext_sel_out(), .rdata_out,
        .rdata_wide_out, .rdata_oe_n_out(oe_n), .peripheral_io_enable_out, .memory_space_map_out,
        .port_a_pin_out(), .port_b_pin_out(), .port_c_pin_out(pc_out), .port_d_pin_out(),
        .port_a_pin_oe_n_out(), .port_b_pin_oe_n_out(), .port_c_pin_oe_n_out(pc_oe_n),
        .port_d_pin_oe_n_out()
    );
    cpu_bus_model cpu (
        .core_clk_in, .rdata_in(rdata_out), .addr_out(addr_in), .wdata_out(wdata_in),
        .rd_n_out(rd_n_in), .wr_n_out(wr_n_in), .fetch_n_out(fetch_n_in)
    );

    // 50 MHz core clock
    initial begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] want);
        checks_done++;
        if (seen !== want) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, want, seen);
        end
    endtask : chk
    // register access always goes through the relocatable base
    task automatic wr(input logic [7:0] o, input logic [7:0] d);
        cpu.xfer(3'b010, {reg_base_in, o}, d, q);
    endtask : wr
    task automatic rchk(input string name, input logic [7:0] o, input logic [15:0] want);
        cpu.xfer(3'b001, {reg_base_in, o}, 8'h00, q);
        chk(name, q, want);
        chk("oe_n", 16'(oe_n), 16'h0000);
    endtask : rchk
    task automatic test_done;
        if (fails == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    // default 8'hFF also proves bits 7, 6, 5 and 0 are masked on load
    initial begin
        {main_hit_in, sec_hit_in, sram_hit_in, ext_hit_in, flash_prog_in, rstn_in} = 6'h00;
        {reg_base_in, csel, cval} = 24'h200000;
        repeat (10) @(posedge core_clk_in);
        #1 rstn_in = 1'b1;
        @(posedge core_clk_in);
        #1 chk("map", 16'(memory_space_map_out), 16'(NV & 8'h1E));
        chk("pio", 16'(peripheral_io_enable_out), 16'h0000);
        rchk("map rd", 8'hE2, 16'(NV & 8'h1E));
        wr(8'hE2, 8'hFF);
        rchk("map rd", 8'hE2, 16'h009E);
        chk("pio", 16'(peripheral_io_enable_out), 16'h0001);
        // k: data main, data sec, fetch main, fetch sec -> map bits 4..1
        foreach (maps[i]) begin
            wr(8'hE2, maps[i]);
            for (int k = 0; k < 4; k++) begin
                {main_hit_in, sec_hit_in} = k[0] ? 2'b01 : 2'b10;
                src = k[0] ? SDAT : MDAT;
                exp = maps[i][4 - k];
                cpu.xfer(k[1] ? 3'b100 : 3'b001, 16'h8000, 8'h00, q);
                chk("sel", 16'(k[0] ? sec_sel_out : main_sel_out), 16'(exp));
                if (exp) chk("wide", 16'(rdata_wide_out), 16'(k[1]));
                if (exp) chk("word", q, k[1] ? src : {8'h00, src[7:0]});
            end
        end
        {main_hit_in, sec_hit_in, sram_hit_in} = 3'b001;
        cpu.xfer(3'b100, {reg_base_in, 8'hE2}, 8'h00, q);
        chk("fetch sram", 16'(sram_sel_out), 16'h0000);
        cpu.xfer(3'b001, 16'h8000, 8'h00, q);
        chk("sram byte", q, 16'h009A);
        {main_hit_in, sram_hit_in, flash_prog_in} = 3'b101;
        cpu.xfer(3'b100, 16'h8000, 8'h00, q);
        chk("prog wide", 16'(rdata_wide_out), 16'h0000);
        {main_hit_in, flash_prog_in} = 2'b00;
        foreach (ofs[i]) wr(ofs[i], ofs[i] ^ 8'hA5);
        foreach (ofs[i]) rchk("port reg", ofs[i], 16'(ofs[i] ^ 8'hA5));
        foreach (pins[i]) begin
            wr(pin_ofs[i], 8'hFF);
            rchk("pin in", pin_ofs[i], 16'(pins[i]));
        end
        wr(8'h08, 8'hFF);
        rchk("unused", 8'h08, 16'h0000);
        chk("pin c", 16'(pc_out), 16'h00B7);
        chk("oe c", 16'(pc_oe_n), 16'h004E);
        {csel, cval} = 16'h0F05;
        repeat (2) @(posedge core_clk_in);
        #1 chk("cell c", 16'(pc_out), 16'h00B5);
        reg_base_in = 8'h40;
        rchk("moved", 8'hE2, 16'h001E);
        // a second reset must drop the runtime override
        wr(8'hE2, 8'h80);
        rstn_in = 1'b0;
        repeat (10) @(posedge core_clk_in);
        #1 rstn_in = 1'b1;
        rchk("map rst", 8'hE2, 16'(NV & 8'h1E));
        chk("pio rst", 16'(peripheral_io_enable_out), 16'h0000);
        test_done();
    end
endmodule : memory_space_routing_regs_tb_top
